// [logic/maf_map.svh]
// Purpose: register offsets, field positions and reset values of the forwarding block
// Assumes: byte addresses on an 8-bit APB address, one 32-bit word per register
// Notes: definitions only
`ifndef MAF_MAP_SVH
`define MAF_MAP_SVH

// widths of port ids and port masks carried in the structs
`define MAF_PORT_W      4
`define MAF_MASK_W      16
`define MAF_PORT_NONE   4'hF

// register byte addresses
`define MAF_A_MIRROR    8'h00
`define MAF_A_MODES     8'h04
`define MAF_A_HASHEN    8'h08
`define MAF_A_STPFWD    8'h0C
`define MAF_A_GRPSTP    8'h10
`define MAF_A_FRAMES    8'h14
`define MAF_A_COPIES    8'h18
`define MAF_A_LINK      8'h1C
`define MAF_A_GRP0      8'h20
`define MAF_GRP_SEL     3'h1

// hash contributor enable bits
`define MAF_H_SMAC      0
`define MAF_H_DMAC      1
`define MAF_H_SIP       2
`define MAF_H_DIP       3
`define MAF_H_L4        4

// group config word: members in the low bits, active limit above
`define MAF_G_LIM_LSB   16

// reset values
`define MAF_R_MIRROR    4'hF
`define MAF_R_HASHEN    5'h1F
`define MAF_R_LIM       4'h0
`endif

// [logic/maf_pkg.sv]
// Purpose: types shared by the forwarding block and its neighbours
// Assumes: port ids of four bits, masks of sixteen bits
// Notes: types only, constants live in maf_map.svh
package maf_pkg;
	// per-port copy setting, bit 0 copies received, bit 1 copies transmitted
	typedef enum logic [1:0]
	{
		MAF_MODE_OFF  = 2'h0,
		MAF_MODE_RX   = 2'h1,
		MAF_MODE_TX   = 2'h2,
		MAF_MODE_BOTH = 2'h3
	} maf_mode_t;

	// frame descriptor handed over by the lookup stage
	typedef struct packed
	{
		logic [3:0]  srcPort;
		logic [3:0]  dstId;
		logic        dstIsGroup;
		logic        isIpv4;
		logic        isL4;
		logic [47:0] srcMac;
		logic [47:0] dstMac;
		logic [31:0] srcIp;
		logic [31:0] dstIp;
		logic [15:0] srcL4;
		logic [15:0] dstL4;
	} maf_desc_t;

	// forwarding decision for one frame
	typedef struct packed
	{
		logic [15:0] mask;
		logic [3:0]  srcPort;
		logic [3:0]  member;
		logic        toGroup;
		logic        mirrored;
	} maf_dec_t;
endpackage

// [logic/maf_fifo.sv]
// Purpose: small descriptor queue with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes: full and empty are registered so ready comes from a flop
`timescale 1ns/1ns
module maf_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		$error("maf_fifo: DEPTH must be a power of two of at least 2");

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_reg, wrPtr_next;
	logic [AW-1:0]    rdPtr_reg, rdPtr_next;
	logic [AW:0]      count_reg, count_next;
	logic             full_reg, full_next;
	logic             empty_reg, empty_next;
	logic             push;
	logic             pop;

	// handshakes and pointer arithmetic
	always_comb
	begin
		push       = inValid && !full_reg;
		pop        = outReady && !empty_reg;
		wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
		rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
		count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
		full_next  = count_next == (AW+1)'(DEPTH);
		empty_next = count_next == '0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
			full_reg  <= 1'b0;
			empty_reg <= 1'b1;
		end
		else
		begin
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
			full_reg  <= full_next;
			empty_reg <= empty_next;
		end
	end

	// storage needs no reset, empty guards the stale words
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wrPtr_reg] <= inData;
	end

	assign inReady  = !full_reg;
	assign outValid = !empty_reg;
	assign outData  = mem[rdPtr_reg];
endmodule

// [logic/maf_forward.sv]
// Purpose: mirror copying and aggregated-group member choice for each frame
// Assumes: descriptors come from logic on clk; link status comes from pins
// Notes: one decision per cycle, held at the output until taken
// Functional notes
// - rx-only source copies arriving frames to the mirror port, never leaving ones.
// - tx-only source copies leaving frames to the mirror port, never arriving ones.
// - both-direction source copies arriving and leaving frames to the mirror port.
// - source with copying off has nothing duplicated toward the mirror port.
// - one mirror destination for all sources; setting it off stops copying.
// - mirror port sends each frame once; its own mode is off or rx only.
// - aggregated group acts as one logical port with ordinary port attributes.
// - group member picked by flow hash, so one flow keeps one member.
// - hash may use both MACs, both IPv4 addresses, L4 ports; each enabled alone.
// - each aggregated group holds up to ten member ports.
// - up to five aggregated groups of gigabit ports.
// - members beyond the active limit wait in standby and replace failed ones.
// - spanning-tree state applies to all members of a group as one unit.
`timescale 1ns/1ns
`include "maf_map.svh"
module maf_forward
#(
	parameter int NUM_PORTS  = 10,
	parameter int NUM_GROUPS = 5,
	parameter int FIFO_DEPTH = 8
)
(
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [NUM_PORTS-1:0] linkUpPin,
	input  maf_pkg::maf_desc_t        inDesc,
	input  wire logic                 inValid,
	output logic                      inReady,
	output maf_pkg::maf_dec_t         outDec,
	output logic                      outValid,
	input  wire logic                 outReady
);
	import maf_pkg::*;
	localparam int PW = `MAF_PORT_W;
	// ids are four bits and the code 15 means no port
	if (NUM_PORTS < 2 || NUM_PORTS > 15)
		$error("maf_forward: NUM_PORTS must lie in 2..15");
	if (NUM_GROUPS < 1 || NUM_GROUPS > 8)
		$error("maf_forward: NUM_GROUPS must lie in 1..8");

	logic [PW-1:0]          mirrorDst_reg, mirrorDst_next;
	logic [2*NUM_PORTS-1:0] portMode_reg, portMode_next;
	logic [4:0]             hashEn_reg, hashEn_next;
	logic [NUM_PORTS-1:0]   stpFwd_reg, stpFwd_next;
	logic [NUM_GROUPS-1:0]  grpStp_reg, grpStp_next;
	logic [NUM_PORTS-1:0]   grpMem_reg [NUM_GROUPS];
	logic [NUM_PORTS-1:0]   grpMem_next [NUM_GROUPS];
	logic [3:0]             grpLim_reg [NUM_GROUPS];
	logic [3:0]             grpLim_next [NUM_GROUPS];
	logic [15:0]            frames_reg, frames_next;
	logic [15:0]            copies_reg, copies_next;
	logic [31:0]            prdata_reg, prdata_next;
	logic                   pready_reg, pready_next;
	logic                   pslverr_reg, pslverr_next;
	logic [NUM_PORTS-1:0]   linkMeta_reg;
	logic [NUM_PORTS-1:0]   linkUp_reg;
	maf_dec_t               outDec_reg, outDec_next;
	logic                   outValid_reg, outValid_next;
	maf_desc_t              desc;
	logic                   descValid;
	logic                   fire;
	logic [7:0]             hash;
	logic [NUM_PORTS-1:0]   active;
	logic [3:0]             grpCount;
	logic [3:0]             memberIdx;
	logic [PW-1:0]          memberId;
	logic                   grpHit;
	logic [NUM_PORTS-1:0]   egMask;
	logic [PW-1:0]          egPort;
	logic                   egAny;
	logic                   mirOn;
	maf_mode_t              srcMode;
	maf_mode_t              egMode;
	logic                   rxCopy;
	logic                   txCopy;
	logic [2:0]             grpSel;
	logic                   isGrp;

	// copy setting of one port, ports outside the range read as off
	function automatic maf_mode_t modeOf(input logic [2*NUM_PORTS-1:0] m, input logic [PW-1:0] p);
		modeOf = MAF_MODE_OFF;
		if (p < PW'(NUM_PORTS))
			modeOf = maf_mode_t'(m[2*p +: 2]);
	endfunction

	// xor fold of a wide field into one hash byte
	function automatic logic [7:0] fold(input logic [47:0] v);
		fold = v[7:0] ^ v[15:8] ^ v[23:16] ^ v[31:24] ^ v[39:32] ^ v[47:40];
	endfunction

	// position of the n-th set bit, counting from bit 0
	function automatic logic [PW-1:0] nthSet(input logic [NUM_PORTS-1:0] m, input logic [3:0] n);
		logic [3:0] seen;
		seen   = 4'h0;
		nthSet = '0;
		for (int i = 0; i < NUM_PORTS; i++)
		begin
			if (m[i])
			begin
				if (seen == n)
					nthSet = PW'(i);
				seen = seen + 4'h1;
			end
		end
	endfunction

	// address decode shared by read mux and write path
	function automatic logic addrOk(input logic [7:0] a);
		addrOk = (a[1:0] == 2'h0) && (a < `MAF_A_GRP0 ||
			(a[7:5] == `MAF_GRP_SEL && 32'(a[4:2]) < NUM_GROUPS));
	endfunction

	// link status from pins, first flop feeds only the second
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			linkMeta_reg <= '0;
			linkUp_reg   <= '0;
		end
		else
		begin
			linkMeta_reg <= linkUpPin;
			linkUp_reg   <= linkMeta_reg;
		end
	end

	// queue absorbs bursts while the consumer stalls the output
	maf_fifo #(.WIDTH($bits(maf_desc_t)), .DEPTH(FIFO_DEPTH)) descQueue
	(
		.clk      (clk),
		.sys_rst  (sys_rst),
		.inData   (inDesc),
		.inValid  (inValid),
		.inReady  (inReady),
		.outData  (desc),
		.outValid (descValid),
		.outReady (fire)
	);

	// flow hash over the enabled contributors only
	always_comb
	begin
		hash = 8'h00;
		if (hashEn_reg[`MAF_H_SMAC])
			hash = hash ^ fold(desc.srcMac);
		if (hashEn_reg[`MAF_H_DMAC])
			hash = hash ^ fold(desc.dstMac);
		if (hashEn_reg[`MAF_H_SIP] && desc.isIpv4)
			hash = hash ^ fold({16'h0000, desc.srcIp});
		if (hashEn_reg[`MAF_H_DIP] && desc.isIpv4)
			hash = hash ^ fold({16'h0000, desc.dstIp});
		if (hashEn_reg[`MAF_H_L4] && desc.isIpv4 && desc.isL4)
			hash = hash ^ fold({16'h0000, desc.srcL4, desc.dstL4});
	end

	// member choice: first up members up to the limit, rest stand by
	always_comb
	begin
		grpSel   = desc.dstId[2:0];
		isGrp    = desc.dstIsGroup && desc.dstId < PW'(NUM_GROUPS);
		active   = '0;
		grpCount = 4'h0;
		if (isGrp)
		begin
			for (int i = 0; i < NUM_PORTS; i++)
			begin
				if (grpMem_reg[grpSel][i] && linkUp_reg[i] &&
					(grpLim_reg[grpSel] == 4'h0 || grpCount < grpLim_reg[grpSel]))
				begin
					active[i] = 1'b1;
					grpCount  = grpCount + 4'h1;
				end
			end
		end
		grpHit    = isGrp && grpCount != 4'h0 && grpStp_reg[grpSel];
		memberIdx = grpCount == 4'h0 ? 4'h0 : 4'(hash % {4'h0, grpCount});
		memberId  = nthSet(active, memberIdx);
	end

	// egress port and mirror copies
	always_comb
	begin
		egMask = '0;
		egPort = `MAF_PORT_NONE;
		if (grpHit)
			egPort = memberId;
		else if (!desc.dstIsGroup && desc.dstId < PW'(NUM_PORTS) && stpFwd_reg[desc.dstId])
			egPort = desc.dstId;
		egAny = egPort != `MAF_PORT_NONE;
		if (egAny)
			egMask[egPort] = 1'b1;
		mirOn   = mirrorDst_reg < PW'(NUM_PORTS);
		srcMode = modeOf(portMode_reg, desc.srcPort);
		egMode  = modeOf(portMode_reg, egPort);
		rxCopy  = mirOn && srcMode[0];
		// a frame leaving on the mirror port is not sent there twice
		txCopy  = mirOn && egAny && egPort != mirrorDst_reg && egMode[1];
		if (rxCopy || txCopy)
			egMask[mirrorDst_reg] = 1'b1;
	end

	// output stage holds a decision until the consumer takes it
	always_comb
	begin
		fire          = descValid && (!outValid_reg || outReady);
		outValid_next = fire || (outValid_reg && !outReady);
		outDec_next   = outDec_reg;
		if (fire)
		begin
			outDec_next.mask     = `MAF_MASK_W'(egMask);
			outDec_next.srcPort  = desc.srcPort;
			outDec_next.member   = grpHit ? memberId : `MAF_PORT_NONE;
			outDec_next.toGroup  = desc.dstIsGroup;
			outDec_next.mirrored = rxCopy || txCopy;
		end
	end

	// apb slave: answer in the first access cycle, writes land on it
	always_comb
	begin
		pready_next    = psel && !penable;
		pslverr_next   = psel && !penable && !addrOk(paddr);
		prdata_next    = 32'h0000_0000;
		mirrorDst_next = mirrorDst_reg;
		portMode_next  = portMode_reg;
		hashEn_next    = hashEn_reg;
		stpFwd_next    = stpFwd_reg;
		grpStp_next    = grpStp_reg;
		grpMem_next    = grpMem_reg;
		grpLim_next    = grpLim_reg;
		frames_next    = fire ? frames_reg + 16'h0001 : frames_reg;
		copies_next    = (fire && (rxCopy || txCopy)) ? copies_reg + 16'h0001 : copies_reg;
		if (psel && !penable)
		begin
			case (paddr)
				`MAF_A_MIRROR: prdata_next = 32'(mirrorDst_reg);
				`MAF_A_MODES:  prdata_next = 32'(portMode_reg);
				`MAF_A_HASHEN: prdata_next = 32'(hashEn_reg);
				`MAF_A_STPFWD: prdata_next = 32'(stpFwd_reg);
				`MAF_A_GRPSTP: prdata_next = 32'(grpStp_reg);
				`MAF_A_FRAMES: prdata_next = 32'(frames_reg);
				`MAF_A_COPIES: prdata_next = 32'(copies_reg);
				`MAF_A_LINK:   prdata_next = 32'(linkUp_reg);
				default:
				begin
					if (addrOk(paddr) && paddr >= `MAF_A_GRP0)
						prdata_next = (32'(grpLim_reg[paddr[4:2]]) << `MAF_G_LIM_LSB)
							| 32'(grpMem_reg[paddr[4:2]]);
				end
			endcase
		end
		if (psel && penable && pready_reg && pwrite && !pslverr_reg)
		begin
			case (paddr)
				`MAF_A_MIRROR: mirrorDst_next = pwdata[PW-1:0];
				`MAF_A_MODES:  portMode_next  = pwdata[2*NUM_PORTS-1:0];
				`MAF_A_HASHEN: hashEn_next    = pwdata[4:0];
				`MAF_A_STPFWD: stpFwd_next    = pwdata[NUM_PORTS-1:0];
				`MAF_A_GRPSTP: grpStp_next    = pwdata[NUM_GROUPS-1:0];
				default:
				begin
					if (paddr >= `MAF_A_GRP0)
					begin
						grpMem_next[paddr[4:2]] = pwdata[NUM_PORTS-1:0];
						grpLim_next[paddr[4:2]] = pwdata[`MAF_G_LIM_LSB +: 4];
					end
				end
			endcase
		end
		// the mirror port can never hold transmit copying
		if (mirrorDst_next < PW'(NUM_PORTS))
			portMode_next[2*mirrorDst_next+1] = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			mirrorDst_reg <= `MAF_R_MIRROR;
			portMode_reg  <= '0;
			hashEn_reg    <= `MAF_R_HASHEN;
			stpFwd_reg    <= '1;
			grpStp_reg    <= '1;
			for (int g = 0; g < NUM_GROUPS; g++)
			begin
				grpMem_reg[g] <= '0;
				grpLim_reg[g] <= `MAF_R_LIM;
			end
			frames_reg    <= 16'h0000;
			copies_reg    <= 16'h0000;
			prdata_reg    <= 32'h0000_0000;
			pready_reg    <= 1'b0;
			pslverr_reg   <= 1'b0;
			outDec_reg    <= '0;
			outValid_reg  <= 1'b0;
		end
		else
		begin
			mirrorDst_reg <= mirrorDst_next;
			portMode_reg  <= portMode_next;
			hashEn_reg    <= hashEn_next;
			stpFwd_reg    <= stpFwd_next;
			grpStp_reg    <= grpStp_next;
			grpMem_reg    <= grpMem_next;
			grpLim_reg    <= grpLim_next;
			frames_reg    <= frames_next;
			copies_reg    <= copies_next;
			prdata_reg    <= prdata_next;
			pready_reg    <= pready_next;
			pslverr_reg   <= pslverr_next;
			outDec_reg    <= outDec_next;
			outValid_reg  <= outValid_next;
		end
	end

	assign prdata   = prdata_reg;
	assign pready   = pready_reg;
	assign pslverr  = pslverr_reg;
	assign outDec   = outDec_reg;
	assign outValid = outValid_reg;

	// checks on decisions, in the cycle the descriptor is taken or one cycle after
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	rx_copy_a: assert property (fire && rxCopy |=> outDec.mirrored && outDec.mask[$past(mirrorDst_reg)])
		else $error("received frame not copied");
	tx_only_a: assert property (fire && srcMode == MAF_MODE_TX && !txCopy |=> !outDec.mirrored)
		else $error("tx-only source copied an arriving frame");
	both_mode_a: assert property (fire && mirOn && srcMode == MAF_MODE_BOTH |=> outDec.mirrored)
		else $error("both-direction source not copied");
	off_mode_a: assert property (fire && srcMode == MAF_MODE_OFF && egMode == MAF_MODE_OFF |=> !outDec.mirrored)
		else $error("copy made with copying off");
	mirror_off_a: assert property (fire && !mirOn |=>
		!outDec.mirrored && $onehot0(outDec.mask)) else $error("copy made with mirror off");
	mirror_tx_a: assert property (mirOn |-> !portMode_reg[2*mirrorDst_reg+1])
		else $error("mirror port holds transmit copying");
	member_pick_a: assert property (fire && grpHit |-> active[memberId] ##1 outDec.mask[outDec.member])
		else $error("group member not an active member");
	hash_none_a: assert property (fire && grpHit && hashEn_reg == 5'h00 |-> memberIdx == 4'h0)
		else $error("disabled hash moved the member");
	member_mod_a: assert property (fire && grpHit |-> memberIdx < grpCount)
		else $error("member index past active count");
	stp_group_a: assert property (fire && isGrp && !grpStp_reg[grpSel] |=> outDec.member == `MAF_PORT_NONE)
		else $error("blocked group still forwarded");
	standby_a: assert property (fire && isGrp && grpLim_reg[grpSel] != 4'h0 |-> grpCount <= grpLim_reg[grpSel])
		else $error("more active members than the limit");
	rx_copy_c: cover property (fire && rxCopy);
	tx_copy_c: cover property (fire && txCopy);
	group_pick_c: cover property (fire && grpHit && memberIdx != 4'h0);
	out_stall_c: cover property (outValid && !outReady ##1 outValid);
endmodule

// [dv/maf_sink.sv]
// Purpose: egress consumer model that takes forwarding decisions
// Assumes: the block holds each decision until it is taken
// Notes: stallMode 0 always ready, 1 random stalls, 2 fully stalled
`timescale 1ns/1ns
module maf_sink
(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  maf_pkg::maf_dec_t outDec,
	input  wire logic         outValid,
	input  wire logic [1:0]   stallMode,
	output logic              outReady
);
	import maf_pkg::*;
	maf_dec_t got[$];
	// ready moves only after an edge, so a taken decision is never seen twice
	always @(posedge clk)
	begin
		if (sys_rst)
			outReady <= 1'b0;
		else
		begin
			if (outValid && outReady)
				got.push_back(outDec);
			outReady <= (stallMode == 2'h0) || (stallMode == 2'h1 && $urandom_range(2) == 0);
		end
	end
endmodule

// [dv/mirror_and_aggregation_forwarding_tb.sv]
// Purpose: self-checking bench for mirror copies and group member choice
// Assumes: one clock, consumer model with stalls on the decision side
// Notes: member choice modelled from the byte-fold xor hash over enabled fields
`timescale 1ns/1ns
`include "maf_map.svh"
module mirror_and_aggregation_forwarding_tb;
	import maf_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [9:0]  linkUpPin = 10'h3FF;
	maf_desc_t   inDesc = '0;
	logic        inValid = 1'b0;
	logic        inReady;
	maf_dec_t    outDec;
	logic        outValid;
	logic        outReady;
	logic [1:0]  stallMode = 2'h1;
	logic [31:0] rd;
	logic        er;
	int          nErrors = 0;
	int          samplesChecked = 0;
	int          nDec = 0;
	maf_forward i_maf_forward (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .linkUpPin(linkUpPin), .inDesc(inDesc), .inValid(inValid),
		.inReady(inReady), .outDec(outDec), .outValid(outValid), .outReady(outReady));
	maf_sink i_maf_sink (.clk(clk), .sys_rst(sys_rst), .outDec(outDec), .outValid(outValid),
		.stallMode(stallMode), .outReady(outReady));
	// 25 MHz
	always #20 clk = ~clk;
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic timeout();
		nErrors++;
		$display("Error at %0t: wait ran out", $time);
		complete_run();
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
			timeout();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge, so a following call never drives psel twice in one step
		@(posedge clk);
	endtask
	function automatic maf_desc_t mk(input int s, input int dst, input logic g);
		logic [223:0] r;
		maf_desc_t    d;
		r = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		d = r[$bits(maf_desc_t)-1:0];
		d.srcPort = 4'(s);
		d.dstId = 4'(dst);
		d.dstIsGroup = g;
		d.isIpv4 = 1'b1;
		d.isL4 = 1'b1;
		return d;
	endfunction
	// expected flow hash: xor of the byte folds of every enabled field
	function automatic logic [7:0] expHash(input maf_desc_t d, input logic [4:0] en);
		logic [47:0] f [5];
		expHash = 8'h00;
		f = '{d.srcMac, d.dstMac, 48'(d.srcIp), 48'(d.dstIp), {16'h0000, d.srcL4, d.dstL4}};
		for (int k = 0; k < 5; k++)
			for (int j = 0; j < 6; j++)
				if (en[k])
					expHash = expHash ^ f[k][8*j +: 8];
	endfunction
	// offer one descriptor, then wait for its decision at the consumer
	task automatic decide(input maf_desc_t d, output maf_dec_t r);
		int i;
		inDesc <= d;
		inValid <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk);
			if (inReady === 1'b1)
				break;
		end
		if (i == 50)
			timeout();
		inValid <= 1'b0;
		for (i = 0; i < 200 && i_maf_sink.got.size() == 0; i++)
			@(posedge clk);
		if (i == 200)
			timeout();
		r = i_maf_sink.got.pop_front();
		nDec++;
	endtask
	task automatic chkUni(input maf_dec_t r, input int dst, input logic c);
		chk({15'h0, r.mask, r.mirrored}, {15'h0, 16'(1 << dst) | (c ? 16'h0200 : 16'h0000), c});
	endtask
	maf_dec_t  r;
	maf_dec_t  r2;
	maf_desc_t d;
	maf_desc_t e;
	int        n;
	initial
	begin
		void'($urandom(30));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, `MAF_A_MIRROR, 32'h0000_0000);
		chk(rd, 32'h0000_000F);
		apb(1'b0, `MAF_A_HASHEN, 32'h0000_0000);
		chk(rd, 32'h0000_001F);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		apb(1'b1, `MAF_A_GRP0 + 8'h10, 32'h0000_0000);
		chk(32'(er), 32'h0000_0000);
		apb(1'b1, `MAF_A_GRP0 + 8'h14, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		// every copy mode on port 1, mirror port 9; port 1 as source then as egress
		apb(1'b1, `MAF_A_MIRROR, 32'h0000_0009);
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, `MAF_A_MODES, 32'(m) << 2);
			decide(mk(1, 2, 1'b0), r);
			chkUni(r, 2, m[0]);
			decide(mk(3, 1, 1'b0), r);
			chkUni(r, 1, m[1]);
			chk(32'(r.srcPort), 32'h0000_0003);
		end
		// mirror port keeps no transmit copying of its own
		apb(1'b1, `MAF_A_MODES, 32'h000C_0000);
		apb(1'b0, `MAF_A_MODES, 32'h0000_0000);
		chk(rd, 32'h0004_0000);
		apb(1'b1, `MAF_A_MODES, 32'h0000_000C);
		apb(1'b1, `MAF_A_MIRROR, 32'h0000_000F);
		decide(mk(1, 2, 1'b0), r);
		chkUni(r, 2, 1'b0);
		apb(1'b1, `MAF_A_MODES, 32'h0000_0000);
		// group 0 on ports 4..7, each contributor alone; other fields reshuffled
		apb(1'b1, `MAF_A_GRP0, 32'h0000_00F0);
		for (int b = 0; b < 5; b++)
		begin
			apb(1'b1, `MAF_A_HASHEN, 32'h0000_0001 << b);
			d = mk(0, 0, 1'b1);
			e = mk(0, 0, 1'b1);
			case (b)
				0: e.srcMac = d.srcMac;
				1: e.dstMac = d.dstMac;
				2: e.srcIp = d.srcIp;
				3: e.dstIp = d.dstIp;
				default:
				begin
					e.srcL4 = d.srcL4;
					e.dstL4 = d.dstL4;
				end
			endcase
			decide(d, r);
			decide(e, r2);
			chk(32'(r2.member), 32'(r.member));
			chk(32'(r.member >= 4 && r.member <= 7), 32'h0000_0001);
			chk(32'(r.mask), 32'(16'h0001 << r.member));
			chk(32'(r.member), 32'(4 + expHash(d, 5'(1 << b)) % 4));
			chk(32'({r.srcPort, r.toGroup}), 32'h0000_0001);
		end
		// zero hash lands on the first active member
		apb(1'b1, `MAF_A_HASHEN, 32'h0000_0000);
		decide(mk(0, 0, 1'b1), r);
		chk(32'(r.member), 32'h0000_0004);
		// limit of one under the full hash: standby members 5..7 carry nothing
		apb(1'b1, `MAF_A_HASHEN, 32'h0000_001F);
		apb(1'b1, `MAF_A_GRP0, 32'h0001_00F0);
		repeat (3)
		begin
			decide(mk(0, 0, 1'b1), r);
			chk(32'(r.member), 32'h0000_0004);
		end
		apb(1'b1, `MAF_A_HASHEN, 32'h0000_0000);
		// limit of two with ports 4 and 5 down: standby 6 steps in
		apb(1'b1, `MAF_A_GRP0, 32'h0002_00F0);
		linkUpPin <= 10'h3CF;
		repeat (4) @(posedge clk);
		decide(mk(0, 0, 1'b1), r);
		chk(32'(r.member), 32'h0000_0006);
		apb(1'b0, `MAF_A_LINK, 32'h0000_0000);
		chk(rd, 32'h0000_03CF);
		apb(1'b1, `MAF_A_GRPSTP, 32'h0000_0000);
		decide(mk(0, 0, 1'b1), r);
		chk(32'({r.mask, r.member}), 32'h0000_000F);
		apb(1'b1, `MAF_A_GRPSTP, 32'h0000_001F);
		linkUpPin <= 10'h3FF;
		// one group with all ten ports
		apb(1'b1, `MAF_A_GRP0, 32'h0000_0000);
		apb(1'b1, `MAF_A_GRP0 + 8'h04, 32'h0000_03FF);
		repeat (4) @(posedge clk);
		decide(mk(0, 1, 1'b1), r);
		chk(32'({r.mask, r.member}), 32'h0000_0010);
		// fill the queue with the consumer stalled, then drain in order
		stallMode <= 2'h2;
		n = 0;
		inDesc <= mk(0, 0, 1'b0);
		inValid <= 1'b1;
		repeat (14)
		begin
			@(posedge clk);
			if (inReady === 1'b1)
			begin
				n++;
				inDesc <= mk(0, n % 4, 1'b0);
			end
		end
		inValid <= 1'b0;
		chk(32'(n >= 8 && n < 14), 32'h0000_0001);
		stallMode <= 2'h1;
		for (int i = 0; i < 400 && i_maf_sink.got.size() < n; i++)
			@(posedge clk);
		chk(32'(i_maf_sink.got.size()), 32'(n));
		for (int k = 0; k < n && i_maf_sink.got.size() > 0; k++)
		begin
			r = i_maf_sink.got.pop_front();
			chk(32'(r.mask), 32'(16'h0001 << (k % 4)));
		end
		// every taken descriptor counts once; copies came only from the mode sweep
		apb(1'b0, `MAF_A_FRAMES, 32'h0000_0000);
		chk(rd, 32'(nDec + n));
		apb(1'b0, `MAF_A_COPIES, 32'h0000_0000);
		chk(rd, 32'h0000_0004);
		complete_run();
	end
endmodule
